// File: core/tsa_pkg.sv
package tsa_pkg;
    localparam int CHANNELS = 4;
    localparam int OUTPUTS = 8;
    localparam int SLOT_BITS = 6;
    localparam int WORD_BITS = 8;
    localparam int BITS_PER_SLOT = 8;
    localparam logic [5:0] SLOT_RESET = 6'h00;
    localparam logic [2:0] BIT_RESET = 3'h0;
    localparam int ACT_TX_POS = 7;
    localparam int ACT_RX_POS = 6;
    localparam logic [1:0] ACT_BOTH = 2'h0;
    localparam logic [1:0] ACT_TX = 2'h1;
    localparam logic [1:0] ACT_RX = 2'h2;
    localparam logic [1:0] ACT_OFF = 2'h3;
    localparam logic [2:0] SHIFT_RESET = 3'h0;
endpackage : tsa_pkg

// File: core/slot_counter.sv
`timescale 1ns/1ps
module slot_counter (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic bclk_fall,
    input wire logic frame_high,
    output logic [5:0] slot,
    output logic running
);
    logic [2:0] bit_reg;
    logic [5:0] slot_reg;
    logic run_reg;
    logic start_reg;
    // frame start seen high is taken on the first falling bit clock after it rises
    wire start_now = bclk_fall && frame_high && !start_reg;
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            bit_reg <= tsa_pkg::BIT_RESET;
            slot_reg <= tsa_pkg::SLOT_RESET;
            run_reg <= 1'b0;
            start_reg <= 1'b0;
        end else if (bclk_fall) begin
            start_reg <= frame_high;
            if (start_now) begin
                bit_reg <= tsa_pkg::BIT_RESET; // RQ16
                slot_reg <= tsa_pkg::SLOT_RESET; // RQ16
                run_reg <= 1'b1;
            end else begin
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    slot_reg <= slot_reg + 6'h01; // RQ16
                end
            end
        end
    end
    assign slot = slot_reg;
    assign running = run_reg;
endmodule : slot_counter

// File: core/time_slot_assigner.sv
`timescale 1ns/1ps
// Operation
// RQ1: eight-bit-clock transmit and receive slots for four codecs
// RQ2: each sync output independently assignable to any of 64 slots
// RQ3: transmit syncs rest low, high eight bit clocks in assigned slot
// RQ4: receive syncs rest low, high eight bit clocks in assigned slot
// RQ5: open-drain slot flag pulls low during any active transmit slot
// RQ6: control words are exactly eight serial bits
// RQ7: transmit action bit first, then receive action bit, then slot bits
// RQ8: control port framed by active-low select, clocked by own clock
// RQ9: host supplies transmit frame start synchronous to bit clock
// RQ10: paired mode: dual pin is receive frame start
// RQ11: unidirectional mode: dual pin is channel select msb
// RQ12: channel select, lsb first, picks outputs; held stable during load
// RQ13: unidirectional mode assigns all eight outputs to transmit frame
// RQ14: transmit and receive syncs controlled independently
// RQ15: bits taken on control clock fall; select rise latches new assignment
// RQ16: counter clears at first bit-clock fall after frame start, steps per 8
// RQ17: six binary slot bits; action 00 both, 01 tx, 10 rx, 11 disable
// RQ18: all outputs low and inhibited until assigned
// RQ19: each output has its own slot register and enable
// RQ20: outputs change only on bit-clock edges
module time_slot_assigner (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic BCLK,
    input wire logic CTRL_SERIAL_IN,
    input wire logic CTRL_SHIFT_CLOCK,
    input wire logic CTRL_SELECT_N,
    input wire logic MODE_PAIRED,
    input wire logic TX_FRAME_START,
    input wire logic RX_FRAME_START,
    input wire logic CHAN_SEL_LSB,
    input wire logic CHAN_SEL_MID,
    output logic TX_SYNC_OUT_0,
    output logic TX_SYNC_OUT_1,
    output logic TX_SYNC_OUT_2,
    output logic TX_SYNC_OUT_3,
    output logic RX_SYNC_OUT_0,
    output logic RX_SYNC_OUT_1,
    output logic RX_SYNC_OUT_2,
    output logic RX_SYNC_OUT_3,
    output logic TX_SLOT_ACTIVE_N_O,
    output logic TX_SLOT_ACTIVE_N_OE
);
    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin
    localparam int NS = 9;
    // select and control clock rest high; resetting them low would fake a select rise
    localparam logic [NS-1:0] PIN_IDLE = 9'h060;
    logic [NS-1:0] meta_reg;
    logic [NS-1:0] sync_reg;
    logic [NS-1:0] pins;
    assign pins = {BCLK, CTRL_SERIAL_IN, CTRL_SHIFT_CLOCK, CTRL_SELECT_N, MODE_PAIRED,
                   TX_FRAME_START, RX_FRAME_START, CHAN_SEL_LSB, CHAN_SEL_MID};
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            meta_reg <= PIN_IDLE;
            sync_reg <= PIN_IDLE;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
        end
    end
    wire bclk_s = sync_reg[8];
    wire din_s = sync_reg[7];
    wire cclk_s = sync_reg[6];
    wire csn_s = sync_reg[5];
    wire paired_s = sync_reg[4];
    wire txfs_s = sync_reg[3];
    wire dual_s = sync_reg[2];
    wire ch0_s = sync_reg[1];
    wire ch1_s = sync_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // edge detection on sampled clocks and select
    logic bclk_d_reg;
    logic cclk_d_reg;
    logic csn_d_reg;
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            bclk_d_reg <= 1'b0;
            cclk_d_reg <= 1'b1;
            csn_d_reg <= 1'b1;
        end else begin
            bclk_d_reg <= bclk_s;
            cclk_d_reg <= cclk_s;
            csn_d_reg <= csn_s;
        end
    end
    wire bclk_fall = bclk_d_reg && !bclk_s;
    wire cclk_fall = cclk_d_reg && !cclk_s;
    wire cs_rise = !csn_d_reg && csn_s;

    ////////////////////////////////////////////////////////////////////////
    // control shifter
    logic [7:0] shift_reg;
    logic [3:0] count_reg;
    logic [2:0] chan_reg;
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            shift_reg <= 8'h00;
            count_reg <= 4'h0;
            chan_reg <= tsa_pkg::SHIFT_RESET;
        end else if (csn_s) begin
            count_reg <= cs_rise ? count_reg : 4'h0;
        end else if (cclk_fall) begin
            shift_reg <= {shift_reg[6:0], din_s}; // RQ15 RQ7
            // select held stable while loading, so capture with each bit
            chan_reg <= {!paired_s && dual_s, ch1_s, ch0_s}; // RQ12 RQ11
            if (count_reg != 4'hF) begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end
    // only an exact eight-bit word is honoured; longer or shorter is dropped
    wire word_ok = cs_rise && (count_reg == 4'(tsa_pkg::WORD_BITS)); // RQ6 RQ8
    wire act_tx_n = shift_reg[tsa_pkg::ACT_TX_POS];
    wire act_rx_n = shift_reg[tsa_pkg::ACT_RX_POS];
    wire [5:0] new_slot = shift_reg[5:0]; // RQ17

    ////////////////////////////////////////////////////////////////////////
    // assignment registers, index 0-3 transmit, 4-7 receive
    logic [5:0] slot_reg [tsa_pkg::OUTPUTS];
    logic [tsa_pkg::OUTPUTS-1:0] en_reg;
    logic [tsa_pkg::OUTPUTS-1:0] pend_reg;
    logic [tsa_pkg::OUTPUTS-1:0] wr_tx;
    logic [tsa_pkg::OUTPUTS-1:0] wr_en;
    logic [tsa_pkg::OUTPUTS-1:0] wr_sel;
    logic [5:0] tx_slot;
    logic [5:0] rx_slot;
    logic tx_run;
    logic rx_run;
    logic [tsa_pkg::OUTPUTS-1:0] fire_reg;
    logic [2:0] tx_bit_reg;
    logic [2:0] rx_bit_reg;
    logic tx_start_reg;
    logic rx_start_reg;
    wire rx_fs = paired_s ? dual_s : txfs_s; // RQ10 RQ13
    // a frame start is taken once, at the first bit-clock fall that sees it high
    wire tx_start_now = txfs_s && !tx_start_reg;
    wire rx_start_now = rx_fs && !rx_start_reg;

    genvar g;
    generate
        for (g = 0; g < tsa_pkg::OUTPUTS; g++) begin : g_out
            localparam bit IS_RX = (g >= tsa_pkg::CHANNELS);
            localparam logic [2:0] IDX = 3'(g);
            localparam logic [1:0] LOW = 2'(g % tsa_pkg::CHANNELS);
            // paired mode addresses a pair; unidirectional addresses one output
            assign wr_sel[g] = word_ok && (paired_s ? (chan_reg[1:0] == LOW)
                                                   : (chan_reg == IDX)); // RQ12 RQ13
            // paired mode: per-direction action bits; unidirectional: 11 disables
            assign wr_en[g] = paired_s ? (IS_RX ? !act_rx_n : !act_tx_n)
                                       : !(act_tx_n && act_rx_n); // RQ17 RQ14
            // in paired mode a direction not named is left alone, except 11 disables
            assign wr_tx[g] = wr_sel[g] && (wr_en[g] || (act_tx_n && act_rx_n));
            wire [5:0] cnt = (IS_RX && paired_s) ? rx_slot : tx_slot;
            wire run = (IS_RX && paired_s) ? rx_run : tx_run;
            wire [2:0] bitc = (IS_RX && paired_s) ? rx_bit_reg : tx_bit_reg;
            wire start = (IS_RX && paired_s) ? rx_start_now : tx_start_now;
            // a slot boundary is the end of bit seven or a fresh frame start
            wire bound = bitc == 3'h7 || start;
            wire [5:0] nxt = start ? tsa_pkg::SLOT_RESET : cnt + 6'h01;
            always_ff @(posedge CLOCK) begin
                if (RESET) begin
                    slot_reg[g] <= tsa_pkg::SLOT_RESET;
                    en_reg[g] <= 1'b0; // RQ18
                    pend_reg[g] <= 1'b0;
                    fire_reg[g] <= 1'b0;
                end else begin
                    if (wr_tx[g]) begin
                        slot_reg[g] <= new_slot; // RQ2 RQ19
                        en_reg[g] <= wr_en[g];
                        pend_reg[g] <= wr_en[g];
                    end else if (bclk_fall && bound) begin
                        pend_reg[g] <= 1'b0; // RQ15
                    end
                    // decided at a slot boundary, then held for the whole slot;
                    // a new write waits a full slot so no pulse is cut short
                    if (bclk_fall && bound) begin
                        fire_reg[g] <= run && en_reg[g] && !pend_reg[g]
                            && nxt == slot_reg[g]; // RQ3 RQ4 RQ20
                    end
                end
            end
            // falls counted while this output stands; one slot is eight of them
            logic [3:0] width_reg;
            always_ff @(posedge CLOCK) begin
                if (RESET || !fire_reg[g]) begin
                    width_reg <= 4'h0;
                end else if (bclk_fall && width_reg != 4'hF) begin
                    width_reg <= width_reg + 4'h1;
                end
            end
            a_pulse_long: assert property (@(posedge CLOCK) disable iff (RESET) // RQ3 RQ4
                width_reg <= 4'h8)
                else $error("sync pulse outlasted its slot");
            a_pulse_whole: assert property (@(posedge CLOCK) disable iff (RESET) // RQ1
                ($fell(fire_reg[g]) && $stable(paired_s)) |-> width_reg == 4'h8)
                else $error("sync pulse ended before a full slot");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // frame counters
    logic [5:0] tx_slot_raw;
    logic [5:0] rx_slot_raw;
    slot_counter u_tx_cnt (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .bclk_fall(bclk_fall),
        .frame_high(txfs_s), // RQ9
        .slot(tx_slot_raw),
        .running(tx_run)
    );
    slot_counter u_rx_cnt (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .bclk_fall(bclk_fall),
        .frame_high(rx_fs),
        .slot(rx_slot_raw),
        .running(rx_run)
    );
    assign tx_slot = tx_slot_raw;
    assign rx_slot = rx_slot_raw;
    // bit position mirror, used to find slot boundaries
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            tx_bit_reg <= 3'h7;
            rx_bit_reg <= 3'h7;
        end else if (bclk_fall) begin
            tx_bit_reg <= tx_start_now ? 3'h0 : tx_bit_reg + 3'h1; // RQ1
            rx_bit_reg <= rx_start_now ? 3'h0 : rx_bit_reg + 3'h1;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            tx_start_reg <= 1'b0;
            rx_start_reg <= 1'b0;
        end else if (bclk_fall) begin
            tx_start_reg <= txfs_s;
            rx_start_reg <= rx_fs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign TX_SYNC_OUT_0 = fire_reg[0];
    assign TX_SYNC_OUT_1 = fire_reg[1];
    assign TX_SYNC_OUT_2 = fire_reg[2];
    assign TX_SYNC_OUT_3 = fire_reg[3];
    assign RX_SYNC_OUT_0 = fire_reg[4];
    assign RX_SYNC_OUT_1 = fire_reg[5];
    assign RX_SYNC_OUT_2 = fire_reg[6];
    assign RX_SYNC_OUT_3 = fire_reg[7];
    // paired: any transmit pulse; unidirectional: any pulse at all
    wire slot_busy = paired_s ? (|fire_reg[3:0]) : (|fire_reg); // RQ5
    assign TX_SLOT_ACTIVE_N_O = 1'b0;
    assign TX_SLOT_ACTIVE_N_OE = slot_busy; // RQ5

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_quiet: assert property (@(posedge CLOCK) RESET |=> fire_reg == '0) // RQ18
        else $error("sync output active after reset");
    a_flag_follows: assert property (@(posedge CLOCK) disable iff (RESET) // RQ5
        (paired_s && $stable(paired_s) && |fire_reg[3:0]) |-> TX_SLOT_ACTIVE_N_OE)
        else $error("slot flag not pulled with transmit pulse");
    a_bclk_only: assert property (@(posedge CLOCK) disable iff (RESET) // RQ20
        !$past(bclk_fall) |-> $stable(fire_reg))
        else $error("sync output moved off a bit clock edge");
    // a pulse already under way may finish its slot, so judge only quiet outputs
    a_disabled_idle: assert property (@(posedge CLOCK) disable iff (RESET) // RQ18
        (en_reg == '0 && fire_reg == '0) |=> fire_reg == '0)
        else $error("disabled output fired");
    a_word_length: assert property (@(posedge CLOCK) disable iff (RESET) // RQ6
        (cs_rise && count_reg != 4'h8) |=> $stable(en_reg))
        else $error("short or long word changed an assignment");
    a_off_clears: assert property (@(posedge CLOCK) disable iff (RESET) // RQ17
        (word_ok && act_tx_n && act_rx_n && wr_sel[0]) |=> !en_reg[0])
        else $error("disable action left output enabled");
    a_slot_store: assert property (@(posedge CLOCK) disable iff (RESET) // RQ2
        wr_tx[1] |=> slot_reg[1] == $past(new_slot))
        else $error("slot number not stored");
    // the pin is only ever pulled low, and only while some sync pulse stands
    a_idle_high: assert property (@(posedge CLOCK) disable iff (RESET) // RQ5
        TX_SLOT_ACTIVE_N_OE |-> (TX_SLOT_ACTIVE_N_O == 1'b0 && fire_reg != '0))
        else $error("open drain pulled outside any sync pulse");
    // slot bookkeeping on each bit-clock fall
    sequence s_tx_start;
        bclk_fall && tx_start_now;
    endsequence
    sequence s_tx_step;
        bclk_fall && !tx_start_now && tx_run && tx_bit_reg == 3'h7;
    endsequence
    sequence s_rx_start;
        bclk_fall && rx_start_now;
    endsequence
    sequence s_rx_step;
        bclk_fall && !rx_start_now && rx_run && rx_bit_reg == 3'h7;
    endsequence
    a_tx_restart: assert property (@(posedge CLOCK) disable iff (RESET) // RQ16
        s_tx_start |=> (tx_slot == tsa_pkg::SLOT_RESET && tx_bit_reg == tsa_pkg::BIT_RESET))
        else $error("transmit slot count not cleared by frame start");
    a_tx_advance: assert property (@(posedge CLOCK) disable iff (RESET) // RQ16
        s_tx_step |=> tx_slot == $past(tx_slot) + 6'h01)
        else $error("transmit slot count did not step after eight bits");
    a_rx_restart: assert property (@(posedge CLOCK) disable iff (RESET) // RQ16
        s_rx_start |=> (rx_slot == tsa_pkg::SLOT_RESET && rx_bit_reg == tsa_pkg::BIT_RESET))
        else $error("receive slot count not cleared by frame start");
    a_rx_advance: assert property (@(posedge CLOCK) disable iff (RESET) // RQ16
        s_rx_step |=> rx_slot == $past(rx_slot) + 6'h01)
        else $error("receive slot count did not step after eight bits");
endmodule : time_slot_assigner

// File: tb/pcm_frame_host.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// backplane side: free-running bit clock and frame starts, 512 bits a frame
module pcm_frame_host #(
    parameter int RX_OFF = 24
) (
    output logic bclk,
    output logic tx_fs,
    output logic rx_fs,
    output int bit_idx
);
    logic clk_q = 1'b0;
    logic tx_q = 1'b0;
    logic rx_q = 1'b0;
    int idx = 0;
    always #40 clk_q = ~clk_q;
    // starts move on the rising edge so the next falling edge sees them settled
    always @(posedge clk_q) begin
        tx_q <= (idx == 511);
        rx_q <= (idx == RX_OFF - 1);
    end
    always @(negedge clk_q) begin
        idx <= (idx == 511) ? 0 : idx + 1;
    end
    assign bclk = clk_q;
    assign tx_fs = tx_q;
    assign rx_fs = rx_q;
    assign bit_idx = idx;
endmodule : pcm_frame_host

// File: tb/pcm_time_slot_assigner_bench.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((exp) !== (got)) begin fail_count++; \
    $display("[ERR] %s expected %0d seen %0d", what, exp, got); end end
module pcm_time_slot_assigner_bench;
    localparam int RX_OFF = 24;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic din = 1'b0;
    logic shift = 1'b1;
    logic sel_n = 1'b1;
    logic mode = 1'b1;
    logic [2:0] chan = 3'h0;
    logic bclk, tx_fs, rx_fs, oe, od;
    logic [7:0] outs;
    int bit_idx, fail_count, total_checks, oe_cnt, res_oe;
    int cnt[8];
    int first[8];
    int res_cnt[8];
    int res_first[8];
    event frame_end;
    initial begin
        forever #5 clock = ~clock;
    end
    pcm_frame_host #(.RX_OFF(RX_OFF)) host (.bclk(bclk), .tx_fs(tx_fs), .rx_fs(rx_fs),
        .bit_idx(bit_idx));
    time_slot_assigner DUT (.CLOCK(clock), .RESET(reset), .BCLK(bclk), .CTRL_SERIAL_IN(din),
        .CTRL_SHIFT_CLOCK(shift), .CTRL_SELECT_N(sel_n), .MODE_PAIRED(mode),
        .TX_FRAME_START(tx_fs), .RX_FRAME_START(mode ? rx_fs : chan[2]),
        .CHAN_SEL_LSB(chan[0]), .CHAN_SEL_MID(chan[1]),
        .TX_SYNC_OUT_0(outs[0]), .TX_SYNC_OUT_1(outs[1]), .TX_SYNC_OUT_2(outs[2]),
        .TX_SYNC_OUT_3(outs[3]), .RX_SYNC_OUT_0(outs[4]), .RX_SYNC_OUT_1(outs[5]),
        .RX_SYNC_OUT_2(outs[6]), .RX_SYNC_OUT_3(outs[7]),
        .TX_SLOT_ACTIVE_N_O(od), .TX_SLOT_ACTIVE_N_OE(oe));
    ////////////////////////////////////////////////////////////////////////////
    // per-frame tally, sampled at the falling edge that closes each bit
    always @(negedge bclk) begin
        for (int k = 0; k < 8; k++) begin
            if (outs[k] === 1'b1) begin
                if (cnt[k] == 0) first[k] = bit_idx;
                cnt[k]++;
            end
        end
        if (oe === 1'b1) oe_cnt++;
        if (bit_idx == 511) begin
            res_cnt = cnt;
            res_first = first;
            res_oe = oe_cnt;
            for (int k = 0; k < 8; k++) cnt[k] = 0;
            oe_cnt = 0;
            -> frame_end;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // host word: channel held for the whole word, n bits msb first
    task send(input logic [2:0] ch, input logic [7:0] w, input int n);
        @(negedge clock);
        chan = ch;
        sel_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = w[7 - i];
            repeat (12) @(negedge clock);
            shift = 1'b0;
            repeat (12) @(negedge clock);
            shift = 1'b1;
        end
        repeat (12) @(negedge clock);
        sel_n = 1'b1;
        repeat (12) @(negedge clock);
    endtask : send
    // -1 marks an output that must stay low; slot numbers otherwise
    task expect_frame(input int ef[8]);
        logic [511:0] m;
        int pos;
        repeat (3) @(frame_end);
        m = '0;
        for (int k = 0; k < 8; k++) begin
            pos = (ef[k] * 8 + ((k > 3 && mode) ? RX_OFF : 0)) % 512;
            `CHK("sync bits", (ef[k] < 0) ? 0 : 8, res_cnt[k])
            if (ef[k] >= 0) begin
                `CHK("sync start", pos, res_first[k])
                for (int j = 0; j < 8; j++) if (k < 4 || !mode) m[(pos + j) % 512] = 1'b1;
            end
        end
        `CHK("flag bits", $countones(m), res_oe)
        `CHK("flag level", 1'b0, od)
    endtask : expect_frame
    ////////////////////////////////////////////////////////////////////////////
    task t_paired;
        send(3'h0, {tsa_pkg::ACT_TX, 6'h00}, 8);
        send(3'h3, {tsa_pkg::ACT_RX, 6'h3F}, 8);
        send(3'h1, {tsa_pkg::ACT_BOTH, 6'h05}, 8);
        send(3'h2, {tsa_pkg::ACT_BOTH, 6'h3F}, 8);
        expect_frame('{0, 5, 63, -1, -1, 5, 63, 63});
        send(3'h1, {tsa_pkg::ACT_OFF, 6'h05}, 8);
        // a short word must be dropped, so channel 0 keeps its slot
        send(3'h0, {tsa_pkg::ACT_OFF, 6'h00}, 7);
        send(3'h3, {tsa_pkg::ACT_TX, 6'h02}, 8);
        expect_frame('{0, -1, 63, 2, -1, -1, 63, 63});
    endtask : t_paired
    task t_unidir;
        mode = 1'b0;
        for (int c = 0; c < 8; c++) send(c[2:0], {tsa_pkg::ACT_OFF, 6'h00}, 8);
        send(3'h5, {tsa_pkg::ACT_BOTH, 6'h0A}, 8);
        send(3'h2, {tsa_pkg::ACT_RX, 6'h0B}, 8);
        send(3'h6, {tsa_pkg::ACT_TX, 6'h0B}, 8);
        expect_frame('{-1, -1, 11, -1, -1, 10, 11, -1});
    endtask : t_unidir
    initial begin
        // twelve frames of about 41 us plus the control words, with margin
        #700000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(negedge clock);
        reset = 1'b0;
        expect_frame('{-1, -1, -1, -1, -1, -1, -1, -1});
        t_paired();
        t_unidir();
        end_sim();
    end
endmodule : pcm_time_slot_assigner_bench
